/* verilog/mci_pkg.sv */
package mci_pkg;
    // ****************************************
    // opcodes handled here
    // ****************************************
    localparam logic [7:0] OP_ROT_DOWN   = 8'h32;
    localparam logic [7:0] OP_ROT_UP     = 8'h33;
    localparam logic [7:0] OP_SET_IMM    = 8'h37;
    localparam logic [7:0] OP_LOAD_IDX   = 8'h38;
    localparam logic [7:0] OP_STORE_ACC  = 8'h39;

    // ****************************************
    // axis parameter, status, directions
    // ****************************************
    localparam logic [7:0] AP_TARGET_VEL = 8'h02;
    localparam logic [7:0] STATUS_OK     = 8'h64;
    localparam logic       DIR_DOWN      = 1'b0;
    localparam logic       DIR_UP        = 1'b1;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic        RST_VEL_MODE = 1'b0;
    localparam logic        RST_DIR      = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_REPLY
    } mci_state_t;
endpackage : mci_pkg

/* verilog/mci_uvar_store.sv */
module mci_uvar_store #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 256
) (
    input  wire logic                     clk_sys_in,
    input  wire logic                     rstn_in,
    input  wire logic                     wr_en_in,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx_in,
    input  wire logic [WIDTH-1:0]         wr_data_in,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx_in,
    output logic      [WIDTH-1:0]         rd_data_out
);
    initial
    begin
        if (WIDTH < 1 || DEPTH < 2)
            $error("mci_uvar_store: bad WIDTH or DEPTH");
    end

    logic [WIDTH-1:0] mem      [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];

    // ****************************************
    // one flip-flop word per entry
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_entry
            always_comb
            begin
                next_mem[g] = mem[g];
                if (wr_en_in && (int'(wr_idx_in) == g))
                    next_mem[g] = wr_data_in;
            end

            always_ff @(posedge clk_sys_in or negedge rstn_in)
            begin
                if (!rstn_in)
                    mem[g] <= '0;
                else
                    mem[g] <= next_mem[g];
            end
        end
    endgenerate

    assign rd_data_out = mem[rd_idx_in];
endmodule : mci_uvar_store

/* verilog/mci_cmd_exec.sv */
// What this block does
// - Rotate-down opcode starts endless motion that lowers position.
// - Rotate-up opcode starts endless motion that raises position.
// - Rotates select velocity mode and write accumulator to param 2 in the same cycle.
// - The accumulator goes to the motion controller unscaled.
// - Set-immediate opcode writes the 32-bit value to uvar[X].
// - Load opcode copies uvar[X] into the accumulator.
// - Store opcode copies the accumulator into uvar[X].
// - X outside 0..255 makes the indexed opcodes change nothing.
// - In direct mode each of the five opcodes above is answered with status OK; unknown opcodes get no reply.
module mci_cmd_exec #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 256
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rstn_in,
    input  wire logic             cmd_valid_in,
    output logic                  cmd_ready_out,
    input  wire logic [7:0]       cmd_opcode_in,
    input  wire logic [7:0]       cmd_type_in,
    input  wire logic [7:0]       cmd_motor_in,
    input  wire logic [WIDTH-1:0] cmd_value_in,
    input  wire logic             direct_mode_in,
    input  wire logic [WIDTH-1:0] accum_in,
    input  wire logic [31:0]      xreg_in,
    output logic                  accum_wr_out,
    output logic      [WIDTH-1:0] accum_wr_data_out,
    output logic                  vel_mode_out,
    output logic                  dir_out,
    output logic                  motion_start_out,
    output logic                  param_wr_out,
    output logic      [7:0]       param_idx_out,
    output logic      [WIDTH-1:0] param_data_out,
    output logic                  idx_reject_out,
    output logic                  unknown_op_out,
    output logic                  reply_valid_out,
    input  wire logic             reply_ready_in,
    output logic      [7:0]       reply_status_out,
    output logic      [7:0]       reply_opcode_out,
    output logic      [WIDTH-1:0] reply_value_out
);
    localparam int IW = $clog2(DEPTH);

    initial
    begin
        if (WIDTH != 32 || DEPTH != 256)
            $error("mci_cmd_exec: index check serves 32 x 256 only");
    end

    // ****************************************
    // state
    // ****************************************
    mci_pkg::mci_state_t state, next_state;
    logic [7:0]       op, next_op;
    logic [WIDTH-1:0] imm, next_imm;
    logic [WIDTH-1:0] acc, next_acc;
    logic [31:0]      xr, next_xr;
    logic             next_accum_wr, next_vel_mode, next_dir, next_start;
    logic             next_param_wr, next_reject, next_unknown;
    logic [7:0]       next_param_idx;
    logic [WIDTH-1:0] next_accum_data, next_param_data;
    logic             idx_ok, is_rot, is_idx, uv_we;
    logic [WIDTH-1:0] uv_rd, uv_wd;

    assign idx_ok = !xr[31] && (xr[30:IW] == '0);
    assign is_rot = (op == mci_pkg::OP_ROT_DOWN) || (op == mci_pkg::OP_ROT_UP);
    assign is_idx = (op == mci_pkg::OP_SET_IMM) || (op == mci_pkg::OP_LOAD_IDX)
                 || (op == mci_pkg::OP_STORE_ACC);

    assign uv_we = (state == mci_pkg::ST_EXEC) && idx_ok
                && ((op == mci_pkg::OP_SET_IMM)
                 || (op == mci_pkg::OP_STORE_ACC));
    assign uv_wd = (op == mci_pkg::OP_SET_IMM) ? imm : acc;

    mci_uvar_store #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_uvar (
        .clk_sys_in  (clk_sys_in),
        .rstn_in     (rstn_in),
        .wr_en_in    (uv_we),
        .wr_idx_in   (xr[IW-1:0]),
        .wr_data_in  (uv_wd),
        .rd_idx_in   (xr[IW-1:0]),
        .rd_data_out (uv_rd)
    );

    assign cmd_ready_out    = (state == mci_pkg::ST_IDLE);
    assign reply_valid_out  = (state == mci_pkg::ST_REPLY);
    assign reply_status_out = mci_pkg::STATUS_OK;
    assign reply_opcode_out = op;
    assign reply_value_out  = mci_pkg::RST_WORD;

    // ****************************************
    // next values
    // ****************************************
    always_comb
    begin
        next_state      = state;
        next_op         = op;
        next_imm        = imm;
        next_acc        = acc;
        next_xr         = xr;
        next_accum_wr   = 1'b0;
        next_accum_data = accum_wr_data_out;
        next_vel_mode   = vel_mode_out;
        next_dir        = dir_out;
        next_start      = 1'b0;
        next_param_wr   = 1'b0;
        next_param_idx  = param_idx_out;
        next_param_data = param_data_out;
        next_reject     = 1'b0;
        next_unknown    = 1'b0;
        unique case (state)
            mci_pkg::ST_IDLE:
            begin
                if (cmd_valid_in)
                begin
                    // type and motor fields are ignored
                    next_op    = cmd_opcode_in;
                    next_imm   = cmd_value_in;
                    next_acc   = accum_in;
                    next_xr    = xreg_in;
                    next_state = mci_pkg::ST_EXEC;
                end
            end
            mci_pkg::ST_EXEC:
            begin
                if (is_rot)
                begin
                    next_dir   = (op == mci_pkg::OP_ROT_UP) ? mci_pkg::DIR_UP
                                                           : mci_pkg::DIR_DOWN;
                    next_start = 1'b1;
                    next_vel_mode   = 1'b1;
                    next_param_wr   = 1'b1;
                    next_param_idx  = mci_pkg::AP_TARGET_VEL;
                    next_param_data = acc;
                end
                if (op == mci_pkg::OP_LOAD_IDX && idx_ok)
                begin
                    next_accum_wr   = 1'b1;
                    next_accum_data = uv_rd;
                end
                next_reject  = is_idx && !idx_ok;
                next_unknown = !is_idx && !is_rot;
                // direct mode answers, standalone does not
                if (direct_mode_in && (is_idx || is_rot))
                    next_state = mci_pkg::ST_REPLY;
                else
                    next_state = mci_pkg::ST_IDLE;
            end
            mci_pkg::ST_REPLY:
            begin
                if (reply_ready_in)
                    next_state = mci_pkg::ST_IDLE;
            end
            default:
            begin
                next_state = mci_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state             <= mci_pkg::ST_IDLE;
            op                <= mci_pkg::RST_BYTE;
            imm               <= mci_pkg::RST_WORD;
            acc               <= mci_pkg::RST_WORD;
            xr                <= mci_pkg::RST_WORD;
            accum_wr_out      <= 1'b0;
            accum_wr_data_out <= mci_pkg::RST_WORD;
            vel_mode_out      <= mci_pkg::RST_VEL_MODE;
            dir_out           <= mci_pkg::RST_DIR;
            motion_start_out  <= 1'b0;
            param_wr_out      <= 1'b0;
            param_idx_out     <= mci_pkg::RST_BYTE;
            param_data_out    <= mci_pkg::RST_WORD;
            idx_reject_out    <= 1'b0;
            unknown_op_out    <= 1'b0;
        end
        else
        begin
            state             <= next_state;
            op                <= next_op;
            imm               <= next_imm;
            acc               <= next_acc;
            xr                <= next_xr;
            accum_wr_out      <= next_accum_wr;
            accum_wr_data_out <= next_accum_data;
            vel_mode_out      <= next_vel_mode;
            dir_out           <= next_dir;
            motion_start_out  <= next_start;
            param_wr_out      <= next_param_wr;
            param_idx_out     <= next_param_idx;
            param_data_out    <= next_param_data;
            idx_reject_out    <= next_reject;
            unknown_op_out    <= next_unknown;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_take(logic [7:0] code);
        cmd_valid_in && cmd_ready_out && cmd_opcode_in == code;
    endsequence

    AST_ROT_DOWN: assert property (
        s_take(mci_pkg::OP_ROT_DOWN) |-> ##2
        (motion_start_out && dir_out == mci_pkg::DIR_DOWN))
        else $error("rotate down did not start downward");
    AST_ROT_UP: assert property (
        s_take(mci_pkg::OP_ROT_UP) |-> ##2
        (motion_start_out && dir_out == mci_pkg::DIR_UP))
        else $error("rotate up did not start upward");
    AST_VEL_PARAM: assert property (
        param_wr_out |-> (vel_mode_out && motion_start_out
        && param_idx_out == mci_pkg::AP_TARGET_VEL))
        else $error("target velocity write without velocity mode");
    AST_RAW_VEL: assert property (
        (s_take(mci_pkg::OP_ROT_UP) or s_take(mci_pkg::OP_ROT_DOWN))
        |-> ##2 (param_wr_out && param_data_out == $past(accum_in, 2)))
        else $error("velocity not the accumulator value");
    AST_SET_IMM: assert property (
        (uv_we && op == mci_pkg::OP_SET_IMM) |=>
        u_uvar.mem[$past(xr[IW-1:0])] == $past(imm))
        else $error("immediate not stored");
    AST_LOAD: assert property (
        accum_wr_out |-> ($past(op) == mci_pkg::OP_LOAD_IDX
        && accum_wr_data_out == $past(uv_rd)))
        else $error("accumulator load wrong");
    AST_STORE: assert property (
        (uv_we && op == mci_pkg::OP_STORE_ACC) |=>
        u_uvar.mem[$past(xr[IW-1:0])] == $past(acc))
        else $error("accumulator not stored");
    AST_RANGE: assert property (
        (state == mci_pkg::ST_EXEC && is_idx && !idx_ok) |->
        (!uv_we ##1 (!accum_wr_out && idx_reject_out)))
        else $error("out of range index changed state");
    AST_REPLY: assert property (
        (state == mci_pkg::ST_EXEC && direct_mode_in && (is_idx || is_rot))
        |=> (reply_valid_out && reply_status_out == mci_pkg::STATUS_OK))
        else $error("no OK reply in direct mode");
    AST_REPLY_HOLD: assert property (
        (reply_valid_out && !reply_ready_in) |=> reply_valid_out)
        else $error("reply withdrawn before it was taken");
    AST_SIGNED: assert property (
        (state == mci_pkg::ST_EXEC && xr[31]) |-> !uv_we)
        else $error("negative index accepted");
endmodule : mci_cmd_exec

/* sim/mci_host_model.sv */
module mci_host_model (
    input  wire logic       clk_sys_in,
    input  wire logic       rstn_in,
    input  wire logic       reply_valid_in,
    input  wire logic [1:0] stall_in,
    output logic            reply_ready_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] wait_cnt;

    always @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wait_cnt        <= 2'h0;
            reply_ready_out <= 1'b0;
        end
        else if (reply_ready_out || !reply_valid_in)
        begin
            wait_cnt        <= 2'h0;
            reply_ready_out <= 1'b0;
        end
        else if (wait_cnt == stall_in)
            reply_ready_out <= 1'b1;
        else
            wait_cnt <= wait_cnt + 2'h1;
    end
endmodule : mci_host_model

/* sim/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // signals and scoreboard
    // ****************************************
    logic        clk_sys_in, rstn_in, cmd_valid_in, cmd_ready_out;
    logic [7:0]  cmd_opcode_in, cmd_type_in, cmd_motor_in, param_idx_out;
    logic [31:0] cmd_value_in, accum_in, xreg_in, accum_wr_data_out;
    logic [31:0] param_data_out, reply_value_out;
    logic        direct_mode_in, accum_wr_out, vel_mode_out, dir_out;
    logic        motion_start_out, param_wr_out, idx_reject_out;
    logic        unknown_op_out, reply_valid_out, reply_ready_in;
    logic [7:0]  reply_status_out, reply_opcode_out;
    logic [1:0]  stall;
    logic [63:0] exp_q[$];
    logic [31:0] mem_m [256];
    logic [7:0]  ops [6] = '{8'h32, 8'h33, 8'h37, 8'h38, 8'h39, 8'h3a};
    int          n_fail, cmp_count, k;
    integer      seed = 32'hcd1ee650;

    mci_cmd_exec dut_u (
        .clk_sys_in        (clk_sys_in),
        .rstn_in           (rstn_in),
        .cmd_valid_in      (cmd_valid_in),
        .cmd_ready_out     (cmd_ready_out),
        .cmd_opcode_in     (cmd_opcode_in),
        .cmd_type_in       (cmd_type_in),
        .cmd_motor_in      (cmd_motor_in),
        .cmd_value_in      (cmd_value_in),
        .direct_mode_in    (direct_mode_in),
        .accum_in          (accum_in),
        .xreg_in           (xreg_in),
        .accum_wr_out      (accum_wr_out),
        .accum_wr_data_out (accum_wr_data_out),
        .vel_mode_out      (vel_mode_out),
        .dir_out           (dir_out),
        .motion_start_out  (motion_start_out),
        .param_wr_out      (param_wr_out),
        .param_idx_out     (param_idx_out),
        .param_data_out    (param_data_out),
        .idx_reject_out    (idx_reject_out),
        .unknown_op_out    (unknown_op_out),
        .reply_valid_out   (reply_valid_out),
        .reply_ready_in    (reply_ready_in),
        .reply_status_out  (reply_status_out),
        .reply_opcode_out  (reply_opcode_out),
        .reply_value_out   (reply_value_out)
    );
    mci_host_model host_u (
        .clk_sys_in      (clk_sys_in),
        .rstn_in         (rstn_in),
        .reply_valid_in  (reply_valid_out),
        .stall_in        (stall),
        .reply_ready_out (reply_ready_in)
    );

    initial
    begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    // ****************************************
    // compare, verdict, stimulus tasks
    // ****************************************
    task cmp_note(input logic [63:0] exp_v, input logic [63:0] got_v);
        cmp_count++;
        if (exp_v !== got_v)
        begin
            n_fail++;
            $display("unexpected at %0t: exp %h got %h", $time, exp_v, got_v);
        end
    endtask : cmp_note

    task check_one(input logic [63:0] got_v);
        logic [63:0] e;
        e = 64'h0;
        if (exp_q.size() > 0)
            e = exp_q.pop_front();
        cmp_note(e, got_v);
    endtask : check_one

    task give_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    task do_op(input logic [7:0] op, input logic [31:0] val, acc, x,
               input logic dm);
        logic [7:0] frm [8];
        logic       ok;
        int         i;
        ok = ($signed(x) >= 0) && ($signed(x) <= 255);
        case (op)
            8'h32, 8'h33:
                exp_q.push_back({4'h1, 17'h0, 2'b11, op[0], 8'h02, acc});
            8'h37: if (ok) mem_m[x[7:0]] = val;
            8'h38: if (ok) exp_q.push_back({4'h2, 28'h0, mem_m[x[7:0]]});
            8'h39: if (ok) mem_m[x[7:0]] = acc;
            default: exp_q.push_back({4'h4, 60'h0});
        endcase
        if (op inside {8'h37, 8'h38, 8'h39} && !ok)
            exp_q.push_back({4'h3, 60'h0});
        if (dm && op inside {[8'h32:8'h33], [8'h37:8'h39]})
            exp_q.push_back({4'h5, 12'h0, 32'h0, 8'h64, op});
        frm = '{8'h01, op, 8'($random(seed)), 8'($random(seed)),
                val[31:24], val[23:16], val[15:8], val[7:0]};
        @(posedge clk_sys_in);
        #1;
        cmd_valid_in = 1'b1;
        cmd_opcode_in = frm[1];
        cmd_type_in = frm[2];
        cmd_motor_in = frm[3];
        cmd_value_in = {frm[4], frm[5], frm[6], frm[7]};
        accum_in = acc;
        xreg_in = x;
        direct_mode_in = dm;
        stall = 2'($random(seed));
        @(posedge clk_sys_in);
        #1;
        cmd_valid_in = 1'b0;
        accum_in = $random(seed);
        xreg_in = $random(seed);
        i = 0;
        do
        begin
            @(posedge clk_sys_in);
            #1;
            i++;
        end while (cmd_ready_out !== 1'b1 && i < 40);
        if (i >= 40)
        begin
            n_fail++;
            give_verdict();
        end
    endtask : do_op
    // ****************************************
    // result monitor
    // ****************************************
    always @(negedge clk_sys_in)
        if (rstn_in)
        begin
            if (param_wr_out)
                check_one({4'h1, 17'h0, vel_mode_out, motion_start_out,
                    dir_out, param_idx_out, param_data_out});
            if (accum_wr_out)
                check_one({4'h2, 28'h0, accum_wr_data_out});
            if (idx_reject_out) check_one({4'h3, 60'h0});
            if (unknown_op_out) check_one({4'h4, 60'h0});
            if (reply_valid_out && reply_ready_in)
                check_one({4'h5, 12'h0, reply_value_out, reply_status_out,
                    reply_opcode_out});
        end
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        {rstn_in, cmd_valid_in, direct_mode_in, stall} = '0;
        {cmd_opcode_in, cmd_type_in, cmd_motor_in} = '0;
        {cmd_value_in, accum_in, xreg_in} = '0;
        for (k = 0; k < 256; k++)
            mem_m[k] = 32'h0;
        repeat (20) @(posedge clk_sys_in);
        #1;
        rstn_in = 1'b1;
        cmp_note(64'h8, {60'h0, cmd_ready_out, reply_valid_out,
            vel_mode_out, dir_out});
        do_op(8'h33, 32'h0, $random(seed), 32'h0, 1'b1);
        do_op(8'h32, 32'h0, 32'hffff_fff0, 32'h0, 1'b1);
        do_op(8'h33, 32'h0, 32'h8000_0001, 32'h0, 1'b0);
        do_op(8'h37, 32'hdead_0001, 32'h0, 32'd0, 1'b1);
        do_op(8'h37, 32'hdead_00ff, 32'h0, 32'd255, 1'b1);
        do_op(8'h37, 32'h1234_5678, 32'h0, 32'd256, 1'b1);
        do_op(8'h39, 32'h0, 32'h5555_aaaa, 32'hffff_ffff, 1'b1);
        do_op(8'h39, 32'h0, 32'h5555_aaaa, 32'h8000_0000, 1'b0);
        do_op(8'h38, 32'h0, 32'h0, 32'd0, 1'b1);
        do_op(8'h38, 32'h0, 32'h0, 32'd255, 1'b1);
        do_op(8'h39, 32'h0, 32'hc0de_0007, 32'd7, 1'b0);
        do_op(8'h38, 32'h0, 32'h0, 32'd7, 1'b1);
        do_op(8'h38, 32'h0, 32'h0, 32'd512, 1'b1);
        for (k = 0; k < 60; k++)
            do_op(ops[{$random(seed)} % 6], $random(seed), $random(seed),
                  $random(seed) % 12, 1'($random(seed)));
        repeat (5) @(posedge clk_sys_in);
        cmp_note(64'h0, 64'(exp_q.size()));
        give_verdict();
    end
endmodule : tb_top
